// ==== calendar_clock_autowake.sv ====
// Calendar clock with second correction, autowake timer and power modes
// How it works
// - Counting keeps fields within calendar value ranges, writes unchecked
// - Years divisible by four get February 29
// - Advance adds, retard removes one second
// - One second adjustment per pulse, any width
// - Arm bit starts countdown of programmed period
// - Interval is period times minute or 2.5s
// - Sleep request ignored while system power present
// - Sleep exits on timer, button or power
// - Display-only mode ignored with power, same wakeups
// - Timer wakeup sets flag, cleared writing zero
`timescale 1ns/1ps
module calendar_clock_autowake
   import rtc_pkg::*;
#(
   parameter int unsigned HALF_SECOND_COUNT = HALF_SECOND_CYCLES
)(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clock_enable,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        system_power_present,
   input  wire logic        push_button_input,
   output logic             low_power_sleep,
   output logic             low_power_display_only,
   output logic             irq
);
   // ==================================================
   // Calendar step
   function automatic logic [36:0] step_second(input logic [36:0] t);
      logic [7:0] yr;
      logic [3:0] mo;
      logic [4:0] dt;
      logic [2:0] wd;
      logic [4:0] hr;
      logic [5:0] mi;
      logic [5:0] se;
      logic [4:0] last;
      {yr, mo, dt, wd, hr, mi, se} = t;
      case (mo)
         FEBRUARY: last = (yr[1:0] == 2'h0) ? 5'd29 : 5'd28;
         4'h4, 4'h6, 4'h9, 4'hb: last = 5'd30;
         default: last = 5'd31;
      endcase
      if (se < SECONDS_MAX) begin
         se = se + 6'h01;
      end else begin
         se = 6'h00;
         if (mi < SECONDS_MAX) begin
            mi = mi + 6'h01;
         end else begin
            mi = 6'h00;
            if (hr < HOURS_MAX) begin
               hr = hr + 5'h01;
            end else begin
               hr = 5'h00;
               wd = (wd >= WEEKDAY_MAX) ? WEEKDAY_RESET : wd + 3'h1;
               if (dt < last) begin
                  dt = dt + 5'h01;
               end else begin
                  dt = DATE_RESET;
                  if (mo < MONTH_MAX) begin
                     mo = mo + 4'h1;
                  end else begin
                     mo = MONTH_RESET;
                     yr = (yr >= YEAR_MAX) ? YEAR_RESET : yr + 8'h01;
                  end
               end
            end
         end
      end
      return {yr, mo, dt, wd, hr, mi, se};
   endfunction

   // ==================================================
   // Bus decode
   logic [15:0] index;
   logic        bus_write;
   logic        bus_setup;
   logic        mapped;
   assign index     = paddr[17:2];
   assign bus_write = psel && penable && pwrite;
   assign bus_setup = psel && !penable;
   assign pready    = 1'b1;
   assign mapped    = (index >= IDX_SECONDS && index <= IDX_CORRECTION) || index == IDX_UNLOCK ||
                      index == IDX_SLEEP_WAKE || index == IDX_IRQ_STATUS || index == IDX_IRQ_MASK ||
                      index == IDX_WAKE_STATUS;
   assign pslverr   = psel && penable && !mapped;

   // ==================================================
   // Calendar, correction and register state
   logic [36:0] calendar, next_calendar;
   logic [23:0] prescale, next_prescale;
   logic        half_phase, next_half_phase;
   logic        unlocked, next_unlocked;
   logic [1:0]  corr_hold, next_corr_hold;
   logic        advance_pending, next_advance_pending;
   logic        retard_pending, next_retard_pending;
   logic [1:0]  irq_status, next_irq_status;
   logic [1:0]  irq_mask, next_irq_mask;
   logic [2:0]  wake_period_count, next_wake_period_count;
   logic        wake_tick_resolution, next_wake_tick_resolution;
   logic        woken_by_timer_flag, next_woken_by_timer_flag;
   logic [31:0] next_prdata;
   logic        half_tick;
   logic        second_tick;
   logic        wake_expire;
   logic        arm_write;
   logic        time_write;
   logic [1:0]  corr_rise;
   power_mode_type mode;

   assign half_tick   = (prescale == 24'(HALF_SECOND_COUNT - 1));
   assign second_tick = half_tick && half_phase;
   assign time_write  = bus_write && unlocked;
   assign arm_write   = bus_write && index == IDX_SLEEP_WAKE && pwdata[CTL_ARM_BIT];
   assign corr_rise   = pwdata[1:0] & ~corr_hold;
   assign irq         = |(irq_status & irq_mask);

   always_comb begin
      next_prescale             = half_tick ? 24'h000000 : prescale + 24'h000001;
      next_half_phase           = half_tick ? !half_phase : half_phase;
      next_calendar             = calendar;
      next_unlocked             = unlocked;
      next_corr_hold            = corr_hold;
      next_advance_pending      = advance_pending;
      next_retard_pending       = retard_pending;
      next_irq_status           = irq_status;
      next_irq_mask             = irq_mask;
      next_wake_period_count    = wake_period_count;
      next_wake_tick_resolution = wake_tick_resolution;
      next_woken_by_timer_flag  = woken_by_timer_flag;
      next_prdata               = prdata;
      if (second_tick) begin
         if (advance_pending && !retard_pending) begin
            next_calendar = step_second(step_second(calendar));
         end else if (!retard_pending || advance_pending) begin
            next_calendar = step_second(calendar);
         end
         next_advance_pending = 1'b0;
         next_retard_pending  = 1'b0;
      end
      if (bus_write) begin
         next_unlocked = (index == IDX_UNLOCK);
         if (time_write) begin
            case (index)
               IDX_SECONDS: next_calendar[5:0]   = pwdata[5:0];
               IDX_MINUTES: next_calendar[11:6]  = pwdata[5:0];
               IDX_HOURS:   next_calendar[16:12] = pwdata[4:0];
               IDX_WEEKDAY: next_calendar[19:17] = pwdata[2:0];
               IDX_DATE:    next_calendar[24:20] = pwdata[4:0];
               IDX_MONTH:   next_calendar[28:25] = pwdata[3:0];
               IDX_YEAR:    next_calendar[36:29] = pwdata[7:0];
               default: ;
            endcase
         end
         // rising bit gives one pending correction
         if (time_write && index == IDX_CORRECTION) begin
            next_corr_hold = pwdata[1:0];
            if (corr_rise[CORR_ADVANCE_BIT]) begin
               next_advance_pending = 1'b1;
            end
            if (corr_rise[CORR_RETARD_BIT]) begin
               next_retard_pending = 1'b1;
            end
         end
         if (index == IDX_SLEEP_WAKE) begin
            next_wake_period_count    = pwdata[2:0];
            next_wake_tick_resolution = pwdata[CTL_RES_BIT];
         end
         if (index == IDX_IRQ_STATUS) begin
            next_irq_status = irq_status & ~pwdata[1:0];
         end
         if (index == IDX_IRQ_MASK) begin
            next_irq_mask = pwdata[1:0];
         end
         if (index == IDX_WAKE_STATUS && !pwdata[0]) begin
            next_woken_by_timer_flag = 1'b0;
         end
      end
      // Events set after clears so a same-cycle event survives
      if (second_tick) begin
         next_irq_status[IRQ_SECOND_BIT] = 1'b1;
      end
      if (wake_expire) begin
         next_irq_status[IRQ_WAKE_BIT] = 1'b1;
      end
      if (wake_expire && mode != MODE_NORMAL) begin
         next_woken_by_timer_flag = 1'b1;
      end
      if (bus_setup) begin
         case (index)
            IDX_SECONDS:     next_prdata = {26'h0, calendar[5:0]};
            IDX_MINUTES:     next_prdata = {26'h0, calendar[11:6]};
            IDX_HOURS:       next_prdata = {27'h0, calendar[16:12]};
            IDX_WEEKDAY:     next_prdata = {29'h0, calendar[19:17]};
            IDX_DATE:        next_prdata = {27'h0, calendar[24:20]};
            IDX_MONTH:       next_prdata = {28'h0, calendar[28:25]};
            IDX_YEAR:        next_prdata = {24'h0, calendar[36:29]};
            IDX_SLEEP_WAKE:  next_prdata = {28'h0, wake_tick_resolution, wake_period_count};
            IDX_IRQ_STATUS:  next_prdata = {30'h0, irq_status};
            IDX_IRQ_MASK:    next_prdata = {30'h0, irq_mask};
            IDX_WAKE_STATUS: next_prdata = {29'h0, low_power_display_only, low_power_sleep, woken_by_timer_flag};
            default:         next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         calendar             <= {YEAR_RESET, MONTH_RESET, DATE_RESET, WEEKDAY_RESET, 5'h00, 6'h00, SECONDS_RESET};
         prescale             <= 24'h000000;
         half_phase           <= 1'b0;
         unlocked             <= 1'b0;
         corr_hold            <= 2'h0;
         advance_pending      <= 1'b0;
         retard_pending       <= 1'b0;
         irq_status           <= 2'h0;
         irq_mask             <= 2'h0;
         wake_period_count    <= WAKE_PERIOD_RESET;
         wake_tick_resolution <= 1'b0;
         woken_by_timer_flag  <= 1'b0;
         prdata               <= 32'h00000000;
      end else if (clock_enable) begin
         calendar             <= next_calendar;
         prescale             <= next_prescale;
         half_phase           <= next_half_phase;
         unlocked             <= next_unlocked;
         corr_hold            <= next_corr_hold;
         advance_pending      <= next_advance_pending;
         retard_pending       <= next_retard_pending;
         irq_status           <= next_irq_status;
         irq_mask             <= next_irq_mask;
         wake_period_count    <= next_wake_period_count;
         wake_tick_resolution <= next_wake_tick_resolution;
         woken_by_timer_flag  <= next_woken_by_timer_flag;
         prdata               <= next_prdata;
      end
   end

   // ==================================================
   // Autowake timer and power modes
   power_mode_type next_mode;
   logic        armed, next_armed;
   logic [6:0]  unit_count, next_unit_count;
   logic [2:0]  period_left, next_period_left;
   logic [6:0]  unit_halves;
   logic        mode_write;
   assign unit_halves = wake_tick_resolution ? WAKE_COARSE_HALVES : WAKE_FINE_HALVES;
   assign wake_expire = armed && half_tick && unit_count == unit_halves - 7'h01 && period_left <= 3'h1;
   assign mode_write  = bus_write && index == IDX_SLEEP_WAKE;
   assign low_power_sleep        = (mode == MODE_SLEEP);
   assign low_power_display_only = (mode == MODE_DISPLAY);

   always_comb begin
      next_armed       = armed;
      next_unit_count  = unit_count;
      next_period_left = period_left;
      next_mode        = mode;
      if (armed && half_tick) begin
         if (unit_count == unit_halves - 7'h01) begin
            next_unit_count  = 7'h00;
            next_period_left = period_left - 3'h1;
            if (period_left <= 3'h1) begin
               next_armed = 1'b0;
            end
         end else begin
            next_unit_count = unit_count + 7'h01;
         end
      end
      // arm loads period written with it
      if (arm_write) begin
         next_armed       = 1'b1;
         next_unit_count  = 7'h00;
         next_period_left = pwdata[2:0];
      end
      case (mode)
         MODE_NORMAL: begin
            if (mode_write && pwdata[CTL_SLEEP_BIT] && !system_power_present) begin
               next_mode = MODE_SLEEP;
            end else if (mode_write && pwdata[CTL_DISPLAY_BIT] && !system_power_present) begin
               next_mode = MODE_DISPLAY;
            end
         end
         MODE_SLEEP, MODE_DISPLAY: begin
            if (wake_expire || push_button_input || system_power_present) begin
               next_mode = MODE_NORMAL;
            end
         end
         default: next_mode = MODE_NORMAL;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         armed       <= 1'b0;
         unit_count  <= 7'h00;
         period_left <= WAKE_PERIOD_RESET;
         mode        <= MODE_NORMAL;
      end else if (clock_enable) begin
         armed       <= next_armed;
         unit_count  <= next_unit_count;
         period_left <= next_period_left;
         mode        <= next_mode;
      end
   end

   // ==================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_feb_end;
      calendar[28:25] == FEBRUARY && calendar[24:20] == 5'd28 && calendar[16:0] == {HOURS_MAX, SECONDS_MAX, SECONDS_MAX};
   endsequence
   sequence s_plain_tick;
      clock_enable && second_tick && !advance_pending && !retard_pending && !bus_write;
   endsequence
   a_seconds_range: assert property (calendar[5:0] <= SECONDS_MAX && calendar[16:12] <= HOURS_MAX)
      else $error("time field out of range");
   a_leap_day: assert property (s_feb_end and s_plain_tick and calendar[30:29] == 2'h0 |=> calendar[24:20] == 5'd29)
      else $error("leap February skipped day 29");
   a_retard_hold: assert property (clock_enable && second_tick && retard_pending && !advance_pending && !bus_write
      |=> calendar[5:0] == $past(calendar[5:0]))
      else $error("retard did not hold seconds");
   a_pulse_once: assert property (clock_enable && second_tick && advance_pending && !bus_write |=> !advance_pending)
      else $error("advance applied more than once");
   a_arm_loads: assert property (clock_enable && arm_write |=> armed && period_left == $past(pwdata[2:0]))
      else $error("arm did not load period");
   a_fine_interval: assert property (clock_enable && arm_write && !pwdata[CTL_RES_BIT] |=> armed [*4])
      else $error("wake timer expired too early");
   a_sleep_ignored: assert property (clock_enable && mode == MODE_NORMAL && system_power_present |=> mode == MODE_NORMAL)
      else $error("low power entered with power present");
   a_button_wakes: assert property (clock_enable && mode != MODE_NORMAL && push_button_input |=> mode == MODE_NORMAL)
      else $error("button did not wake");
   a_timer_flag: assert property (clock_enable && mode != MODE_NORMAL && wake_expire |=> woken_by_timer_flag)
      else $error("timer wake flag not set");
   a_plain_tick: assert property (s_plain_tick and calendar[5:0] < SECONDS_MAX |=> calendar[5:0] == $past(calendar[5:0]) + 6'h01)
      else $error("seconds did not advance");
   a_one_expire: assert property (clock_enable && wake_expire && !arm_write |=> !armed)
      else $error("timer stayed armed after expiry");
endmodule

// ==== rtc_pkg.sv ====
// Constants, register map and types for the calendar clock with autowake
package rtc_pkg;
   // ==================================================
   // Timing
   localparam int unsigned CLOCK_PERIOD_NS    = 40;
   localparam int unsigned HALF_SECOND_MS     = 500;
   localparam int unsigned HALF_SECOND_CYCLES = HALF_SECOND_MS * 1000000 / CLOCK_PERIOD_NS;
   localparam int unsigned WAKE_FINE_MS       = 2500;
   localparam int unsigned WAKE_COARSE_MS     = 60000;
   localparam logic [6:0]  WAKE_FINE_HALVES   = 7'(WAKE_FINE_MS / HALF_SECOND_MS);
   localparam logic [6:0]  WAKE_COARSE_HALVES = 7'(WAKE_COARSE_MS / HALF_SECOND_MS);
   // ==================================================
   // Register indices, byte address is four times the index
   localparam logic [15:0] IDX_SECONDS     = 16'h2015;
   localparam logic [15:0] IDX_MINUTES     = 16'h2016;
   localparam logic [15:0] IDX_HOURS       = 16'h2017;
   localparam logic [15:0] IDX_WEEKDAY     = 16'h2018;
   localparam logic [15:0] IDX_DATE        = 16'h2019;
   localparam logic [15:0] IDX_MONTH       = 16'h201a;
   localparam logic [15:0] IDX_YEAR        = 16'h201b;
   localparam logic [15:0] IDX_CORRECTION  = 16'h201c;
   localparam logic [15:0] IDX_UNLOCK      = 16'h201f;
   localparam logic [15:0] IDX_SLEEP_WAKE  = 16'h20a9;
   localparam logic [15:0] IDX_IRQ_STATUS  = 16'h20b0;
   localparam logic [15:0] IDX_IRQ_MASK    = 16'h20b1;
   localparam logic [15:0] IDX_WAKE_STATUS = 16'h20b2;
   // ==================================================
   // Field positions
   localparam int unsigned CORR_ADVANCE_BIT = 0;
   localparam int unsigned CORR_RETARD_BIT  = 1;
   localparam int unsigned CTL_ARM_BIT      = 7;
   localparam int unsigned CTL_SLEEP_BIT    = 6;
   localparam int unsigned CTL_DISPLAY_BIT  = 5;
   localparam int unsigned CTL_RES_BIT      = 3;
   localparam int unsigned IRQ_SECOND_BIT   = 0;
   localparam int unsigned IRQ_WAKE_BIT     = 1;
   // ==================================================
   // Reset values
   localparam logic [5:0] SECONDS_RESET     = 6'h00;
   localparam logic [2:0] WEEKDAY_RESET     = 3'h1;
   localparam logic [4:0] DATE_RESET        = 5'h01;
   localparam logic [3:0] MONTH_RESET       = 4'h1;
   localparam logic [7:0] YEAR_RESET        = 8'h00;
   localparam logic [2:0] WAKE_PERIOD_RESET = 3'h1;
   // ==================================================
   // Limits
   localparam logic [5:0] SECONDS_MAX = 6'h3b;
   localparam logic [4:0] HOURS_MAX   = 5'h17;
   localparam logic [2:0] WEEKDAY_MAX = 3'h7;
   localparam logic [3:0] MONTH_MAX   = 4'hc;
   localparam logic [7:0] YEAR_MAX    = 8'h63;
   localparam logic [3:0] FEBRUARY    = 4'h2;
   typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_DISPLAY} power_mode_type;
endpackage

// ==== tb_calendar_clock_autowake.sv ====
// Self-checking bench for the calendar clock with autowake
`timescale 1ns/1ps
module tb_calendar_clock_autowake;
   import rtc_pkg::*;
   // ==================================================
   // Signals
   // A short half second keeps the long wake counts inside the run budget
   localparam int unsigned HALF = 40;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        clock_enable = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        system_power_present = 1'b1;
   logic        push_button_input = 1'b0;
   logic        low_power_sleep;
   logic        low_power_display_only;
   logic        irq;
   logic        last_err;
   logic [31:0] rd;
   int          mismatches = 0;
   int          n_checks = 0;
   // Year, month, date, weekday, then expected year, month, date
   logic [7:0]  cal [7][7] = '{'{8'h00, 8'h02, 8'h1c, 8'h03, 8'h00, 8'h02, 8'h1d},
                              '{8'h04, 8'h02, 8'h1c, 8'h03, 8'h04, 8'h02, 8'h1d},
                              '{8'h01, 8'h02, 8'h1c, 8'h03, 8'h01, 8'h03, 8'h01},
                              '{8'h04, 8'h02, 8'h1d, 8'h05, 8'h04, 8'h03, 8'h01},
                              '{8'h05, 8'h04, 8'h1e, 8'h02, 8'h05, 8'h05, 8'h01},
                              '{8'h05, 8'h01, 8'h1f, 8'h06, 8'h05, 8'h02, 8'h01},
                              '{8'h63, 8'h0c, 8'h1f, 8'h07, 8'h00, 8'h01, 8'h01}};
   calendar_clock_autowake #(.HALF_SECOND_COUNT(HALF)) calendar_clock_autowake_i (
      .clock(clock), .rst_n(rst_n), .clock_enable(clock_enable), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .system_power_present(system_power_present),
      .push_button_input(push_button_input), .low_power_sleep(low_power_sleep),
      .low_power_display_only(low_power_display_only), .irq(irq));
   always #20 clock = ~clock;
   // ==================================================
   // Tasks
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One idle cycle after each transfer so no signal is assigned twice in a step
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      // A wait that never sees pready is ended by the watchdog
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [31:0] msk, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(rd & msk, exp);
   endtask
   task automatic wt(input logic [15:0] idx, input logic [31:0] val);
      apb(1'b1, IDX_UNLOCK, 32'h0);
      apb(1'b1, idx, val);
   endtask
   // Clear first, since a stale sticky bit would return at once unsynchronised
   task automatic wait_tick();
      int n;
      n = 0;
      apb(1'b1, IDX_IRQ_STATUS, 32'h1);
      while (irq !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      chk1(irq, 1'b1);
   endtask
   task automatic chk1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask
   // ==================================================
   // Watchdog
   initial begin
      repeat (40000) @(posedge clock);
      mismatches++;
      give_verdict();
   end
   // ==================================================
   // Tests
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rdchk(IDX_SECONDS, 32'hffffffff, 32'h0);
      rdchk(IDX_MONTH, 32'hffffffff, 32'h1);
      rdchk(IDX_DATE, 32'hffffffff, 32'h1);
      rdchk(IDX_WEEKDAY, 32'hffffffff, 32'h1);
      rdchk(IDX_YEAR, 32'hffffffff, 32'h0);
      rdchk(IDX_SLEEP_WAKE, 32'hffffffff, 32'h1);
      rdchk(IDX_CORRECTION, 32'hffffffff, 32'h0);
      rdchk(16'h2100, 32'hffffffff, 32'h0);
      chk1(last_err, 1'b1);
      chk1(pready, 1'b1);
      apb(1'b1, IDX_IRQ_MASK, 32'h1);
      wait_tick();
      wt(IDX_SECONDS, 32'ha);
      apb(1'b1, IDX_MINUTES, 32'h7);
      apb(1'b1, IDX_UNLOCK, 32'h0);
      apb(1'b1, IDX_IRQ_MASK, 32'h1);
      apb(1'b1, IDX_HOURS, 32'h5);
      rdchk(IDX_SECONDS, 32'hffffffff, 32'ha);
      rdchk(IDX_MINUTES, 32'hffffffff, 32'h0);
      rdchk(IDX_HOURS, 32'hffffffff, 32'h0);
      // Calendar carries across month, leap and century ends
      for (int i = 0; i < 7; i++) begin
         wait_tick();
         wt(IDX_SECONDS, 32'h3b);
         wt(IDX_MINUTES, 32'h3b);
         wt(IDX_HOURS, 32'h17);
         wt(IDX_DATE, {24'h0, cal[i][2]});
         wt(IDX_MONTH, {24'h0, cal[i][1]});
         wt(IDX_YEAR, {24'h0, cal[i][0]});
         wt(IDX_WEEKDAY, {24'h0, cal[i][3]});
         wait_tick();
         rdchk(IDX_SECONDS, 32'hff, 32'h0);
         rdchk(IDX_MINUTES, 32'hff, 32'h0);
         rdchk(IDX_HOURS, 32'hff, 32'h0);
         rdchk(IDX_DATE, 32'hff, {24'h0, cal[i][6]});
         rdchk(IDX_MONTH, 32'hff, {24'h0, cal[i][5]});
         rdchk(IDX_YEAR, 32'hff, {24'h0, cal[i][4]});
         rdchk(IDX_WEEKDAY, 32'hff, (cal[i][3] == 8'h07) ? 32'h1 : 32'(cal[i][3] + 8'h01));
      end
      // Held advance bit gives one extra second only
      wait_tick();
      wt(IDX_SECONDS, 32'ha);
      wt(IDX_CORRECTION, 32'h1);
      wait_tick();
      rdchk(IDX_SECONDS, 32'hff, 32'hc);
      wait_tick();
      rdchk(IDX_SECONDS, 32'hff, 32'hd);
      wt(IDX_CORRECTION, 32'h0);
      wait_tick();
      wait_tick();
      wait_tick();
      wt(IDX_SECONDS, 32'ha);
      wt(IDX_CORRECTION, 32'h2);
      wait_tick();
      rdchk(IDX_SECONDS, 32'hff, 32'ha);
      wt(IDX_CORRECTION, 32'h0);
      // Low clock enable freezes the prescaler and calendar
      clock_enable <= 1'b0;
      repeat (3 * HALF) @(posedge clock);
      clock_enable <= 1'b1;
      rdchk(IDX_SECONDS, 32'hff, 32'ha);
      // Low-power requests while powered are dropped
      apb(1'b1, IDX_SLEEP_WAKE, 32'h41);
      chk1(low_power_sleep, 1'b0);
      apb(1'b1, IDX_SLEEP_WAKE, 32'h21);
      chk1(low_power_display_only, 1'b0);
      system_power_present <= 1'b0;
      apb(1'b1, IDX_SLEEP_WAKE, 32'h40);
      chk1(low_power_sleep, 1'b1);
      system_power_present <= 1'b1;
      repeat (2) @(posedge clock);
      chk1(low_power_sleep, 1'b0);
      system_power_present <= 1'b0;
      apb(1'b1, IDX_SLEEP_WAKE, 32'h20);
      chk1(low_power_display_only, 1'b1);
      push_button_input <= 1'b1;
      repeat (2) @(posedge clock);
      chk1(low_power_display_only, 1'b0);
      push_button_input <= 1'b0;
      // Armed sleep, two fine units of five half seconds each
      apb(1'b1, IDX_IRQ_MASK, 32'h2);
      apb(1'b1, IDX_IRQ_STATUS, 32'h3);
      apb(1'b1, IDX_SLEEP_WAKE, 32'h82);
      apb(1'b1, IDX_SLEEP_WAKE, 32'h42);
      repeat (9 * HALF - 20) @(posedge clock);
      chk1(low_power_sleep, 1'b1);
      chk1(irq, 1'b0);
      repeat (HALF + 30) @(posedge clock);
      chk1(low_power_sleep, 1'b0);
      chk1(irq, 1'b1);
      rdchk(IDX_WAKE_STATUS, 32'h1, 32'h1);
      apb(1'b1, IDX_WAKE_STATUS, 32'h0);
      rdchk(IDX_WAKE_STATUS, 32'h1, 32'h0);
      apb(1'b1, IDX_IRQ_STATUS, 32'h2);
      chk1(irq, 1'b0);
      // Coarse resolution, one minute is 120 half seconds
      apb(1'b1, IDX_SLEEP_WAKE, 32'h89);
      repeat (119 * HALF - 60) @(posedge clock);
      rdchk(IDX_IRQ_STATUS, 32'h2, 32'h0);
      repeat (HALF + 60) @(posedge clock);
      rdchk(IDX_IRQ_STATUS, 32'h2, 32'h2);
      give_verdict();
   end
endmodule
